// >>> include/asr_pkg.sv
// Constants for the angle speed, turn count and frame sync readout registers
package asr_pkg;
    // Register offsets on the serial register port
    localparam logic [5:0] SPEED_OFFSET = 6'h03;
    localparam logic [5:0] TURN_OFFSET = 6'h04;
    localparam logic [5:0] SYNC_OFFSET = 6'h05;
    // Field positions
    localparam int NEW_FLAG_BIT = 15;
    localparam int SPEED_MSB = 14;
    localparam int FRAME_LSB = 9;
    localparam int TURN_MSB = 8;
    localparam int TEMP_MSB = 8;
    // Reset values
    localparam logic [15:0] SPEED_RESET = 16'h8000;
    localparam logic [15:0] TURN_RESET = 16'h8000;
    localparam logic [15:0] SYNC_RESET = 16'h0000;
    // Internal processing clock and update periods
    localparam real PROC_CLK_KHZ = 750.0;
    localparam real SYS_CLK_MHZ = 40.0;
    localparam int PROC_DIV = int'(SYS_CLK_MHZ * 1000.0 / PROC_CLK_KHZ);
    localparam real UPD_US_01 = 42.7;
    localparam real UPD_US_10 = 85.3;
    localparam real UPD_US_11 = 170.6;
    // Sub-counter maxima per update-rate code
    localparam logic [7:0] SUB_MAX_00 = 8'h10;
    localparam logic [7:0] SUB_MAX_01 = 8'h20;
    localparam logic [7:0] SUB_MAX_10 = 8'h40;
    localparam logic [7:0] SUB_MAX_11 = 8'h80;
    // Temperature saturation limits in digits (host offset 152, 2.776 dig/C)
    localparam logic signed [8:0] TEMP_LOW = -9'sd235;
    localparam logic signed [8:0] TEMP_HIGH = 9'sd236;
endpackage

// >>> design/asr_readout.sv
// Speed, turn count, frame counter and temperature readout registers
//
// Behaviour
// - Speed fresh flag bit 15 set on new result, cleared by any read.
// - After snapshot following a read, flag stays clear unless newer speed.
// - Speed is signed 15 bits in 14:0, bit 14 gives direction.
// - Unpredicted speed is current angle minus angle two updates earlier.
// - Predicted speed is predicted angle minus unpredicted angle two updates back.
// - Turn fresh flag bit 15 set on new count, cleared by any read.
// - After snapshot following a read, turn flag clear unless newer count.
// - Unsigned 6-bit frame counter in 14:9 advances every update period.
// - Signed 9-bit turn count: +1 at 360-to-0 wrap, -1 at 0-to-360.
// - Sub-counter in 15:9 advances each 750 kHz internal cycle.
// - Sub-counter maximum is 16, 32, 64 or 128 by update-rate code.
// - Temperature signed 9 bits in 8:0, saturated near -30 and +140 C.
// - Temperature derived from raw measurement and stored 25 C offset.
// - Update periods 42.7, 85.3, 170.6 us for codes 01, 10, 11.
`timescale 1ns/1ps
module asr_readout #(
    parameter int ANGLE_W = 15,
    parameter int SUB_W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Angle source from the processing unit
    input wire logic angleValid,
    input wire logic [14:0] angleRaw,
    input wire logic [14:0] anglePredicted,
    input wire logic predictEnable,
    // Temperature source
    input wire logic [8:0] tempRaw,
    input wire logic [8:0] offsetTemperature25c,
    // Configuration
    input wire logic [1:0] updateRateSelect,
    // Register read port
    input wire logic regRead,
    input wire logic [5:0] regAddr,
    input wire logic snapshot,
    input wire logic snapRead,
    output logic [15:0] regRdata,
    output logic regRvalid
);
    initial begin
        if (ANGLE_W != 15 || SUB_W != 8) begin
            $error("asr_readout supports ANGLE_W 15 and SUB_W 8 only");
        end
    end

    // Wrapping angle difference; the 15-bit two's complement result carries the direction
    function automatic logic [14:0] angleDiff(input logic [14:0] a, input logic [14:0] b);
        angleDiff = a - b;
    endfunction

    logic [14:0] anglePrev1Reg;
    logic [14:0] anglePrev2Reg;
    logic [14:0] speedReg;
    logic speedFlagReg;
    logic [8:0] turnReg;
    logic turnFlagReg;
    logic [5:0] frameReg;
    logic [7:0] subReg;
    logic [5:0] divReg;
    logic [8:0] tempReg;
    logic [15:0] snapSpeedReg;
    logic [15:0] snapTurnReg;
    logic [15:0] snapSyncReg;
    logic [15:0] regRdataReg;
    logic regRvalidReg;

    // Speed difference, direction in bit 14 of the two's complement result
    wire logic [14:0] speedNext = predictEnable ? angleDiff(anglePredicted, anglePrev2Reg)
                                               : angleDiff(angleRaw, anglePrev2Reg);
    // Wrap detection: top two angle bits go from 11 to 00 (ccw) or 00 to 11 (cw)
    wire logic wrapCcw = angleValid && anglePrev1Reg[14:13] == 2'b11 && angleRaw[14:13] == 2'b00;
    wire logic wrapCw = angleValid && anglePrev1Reg[14:13] == 2'b00 && angleRaw[14:13] == 2'b11;
    wire logic [8:0] turnNext = wrapCcw ? turnReg + 9'h001 :
                                wrapCw ? turnReg - 9'h001 : turnReg;
    // Sub-counter maximum selected by update rate
    wire logic [7:0] subMax = (updateRateSelect == 2'b00) ? asr_pkg::SUB_MAX_00 :
                              (updateRateSelect == 2'b01) ? asr_pkg::SUB_MAX_01 :
                              (updateRateSelect == 2'b10) ? asr_pkg::SUB_MAX_10 :
                              asr_pkg::SUB_MAX_11;
    wire logic procTick = divReg == 6'(asr_pkg::PROC_DIV - 1);
    wire logic frameEnd = procTick && subReg >= subMax;
    // Offset compensated temperature, clamped to the saturation window
    wire logic signed [9:0] tempSum = $signed({tempRaw[8], tempRaw}) -
                                      $signed({offsetTemperature25c[8], offsetTemperature25c});
    wire logic [8:0] tempNext = (tempSum < 10'(asr_pkg::TEMP_LOW)) ? asr_pkg::TEMP_LOW :
                                (tempSum > 10'(asr_pkg::TEMP_HIGH)) ? asr_pkg::TEMP_HIGH :
                                tempSum[8:0];
    // Live register views
    wire logic [15:0] speedView = {speedFlagReg, speedReg};
    wire logic [15:0] turnView = {turnFlagReg, frameReg, turnReg};
    wire logic [15:0] syncView = {subReg[6:0], tempReg};
    wire logic hitSpeed = regRead && regAddr == asr_pkg::SPEED_OFFSET;
    wire logic hitTurn = regRead && regAddr == asr_pkg::TURN_OFFSET;
    wire logic hitSync = regRead && regAddr == asr_pkg::SYNC_OFFSET;
    wire logic [15:0] liveData = hitSpeed ? speedView : hitTurn ? turnView :
                                 hitSync ? syncView : 16'h0000;
    wire logic [15:0] snapData = hitSpeed ? snapSpeedReg : hitTurn ? snapTurnReg :
                                 hitSync ? snapSyncReg : 16'h0000;

    // Angle history and speed result, one entry per update
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            anglePrev1Reg <= 15'h0000;
            anglePrev2Reg <= 15'h0000;
            speedReg <= 15'h0000;
            turnReg <= 9'h000;
        end else if (angleValid) begin
            anglePrev1Reg <= angleRaw;
            anglePrev2Reg <= anglePrev1Reg;
            speedReg <= speedNext;
            turnReg <= turnNext;
        end
    end

    // Fresh flags: a new value wins over a clear in the same cycle. A snapshot copies
    // the flag and then clears it, so the following read only sees 1 for newer data.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            speedFlagReg <= asr_pkg::SPEED_RESET[asr_pkg::NEW_FLAG_BIT];
            turnFlagReg <= asr_pkg::TURN_RESET[asr_pkg::NEW_FLAG_BIT];
        end else begin
            if (angleValid) begin
                speedFlagReg <= 1'b1;
            end else if (hitSpeed || snapshot) begin
                speedFlagReg <= 1'b0;
            end
            if (wrapCcw || wrapCw) begin
                turnFlagReg <= 1'b1;
            end else if (hitTurn || snapshot) begin
                turnFlagReg <= 1'b0;
            end
        end
    end

    // Snapshot buffer; its flags clear when the buffered copy is read
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            snapSpeedReg <= 16'h0000;
            snapTurnReg <= 16'h0000;
            snapSyncReg <= asr_pkg::SYNC_RESET;
        end else if (snapshot) begin
            snapSpeedReg <= speedView;
            snapTurnReg <= turnView;
            snapSyncReg <= syncView;
        end else if (snapRead) begin
            if (hitSpeed) begin
                snapSpeedReg[asr_pkg::NEW_FLAG_BIT] <= 1'b0;
            end
            if (hitTurn) begin
                snapTurnReg[asr_pkg::NEW_FLAG_BIT] <= 1'b0;
            end
        end
    end

    // 750 kHz tick, frame sub-counter and frame counter
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            divReg <= 6'h00;
            subReg <= 8'h00;
            frameReg <= 6'h00;
            tempReg <= 9'h000;
        end else begin
            divReg <= procTick ? 6'h00 : divReg + 6'h01;
            if (frameEnd) begin
                subReg <= 8'h00;
                frameReg <= frameReg + 6'h01;
                tempReg <= tempNext;
            end else if (procTick) begin
                subReg <= subReg + 8'h01;
            end
        end
    end

    // Read data is registered; unmapped offsets read zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            regRdataReg <= 16'h0000;
            regRvalidReg <= 1'b0;
        end else begin
            regRdataReg <= snapRead ? snapData : liveData;
            regRvalidReg <= regRead;
        end
    end

    assign regRdata = regRdataReg;
    assign regRvalid = regRvalidReg;
endmodule

// >>> bench/asr_readout_properties.sv
// Port checker for the speed, turn and sync readout registers
`timescale 1ns/1ps
module asr_readout_properties (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Processing unit sources
    input wire logic angleValid,
    input wire logic [14:0] angleRaw,
    input wire logic [14:0] anglePredicted,
    input wire logic predictEnable,
    input wire logic [8:0] tempRaw,
    input wire logic [8:0] offsetTemperature25c,
    input wire logic [1:0] updateRateSelect,
    // Register read port
    input wire logic regRead,
    input wire logic [5:0] regAddr,
    input wire logic snapshot,
    input wire logic snapRead,
    input wire logic [15:0] regRdata,
    input wire logic regRvalid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Read decodes; buffer reads are left out of rdS and rdT since they carry older flags, but rdY counts them
    wire rdS = regRead && regAddr == asr_pkg::SPEED_OFFSET && !snapRead;
    wire rdT = regRead && regAddr == asr_pkg::TURN_OFFSET && !snapRead;
    wire rdY = regRead && regAddr == asr_pkg::SYNC_OFFSET;
    wire unmapped = regAddr < asr_pkg::SPEED_OFFSET || regAddr > asr_pkg::SYNC_OFFSET;
    a_read_answered: assert property (regRead |=> regRvalid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!regRead |=> !regRvalid)
        else $error("answer without request");
    a_unmapped_zero: assert property (regRead && unmapped |=> regRdata == 16'h0000)
        else $error("unmapped read not zero");
    a_speed_flag_clear: assert property ((rdS && !angleValid) ##1 !angleValid ##1 rdS
        |=> !regRdata[15])
        else $error("speed flag survived read");
    a_turn_flag_clear: assert property ((rdT && !angleValid) ##1 !angleValid ##1 rdT
        |=> !regRdata[15])
        else $error("turn flag survived read");
    a_sub_max: assert property (rdY && updateRateSelect == 2'b00 |=> regRdata[15:9] <= 7'd16)
        else $error("sub-counter above maximum");
    a_temp_clamp: assert property (rdY |=> $signed(regRdata[8:0]) >= asr_pkg::TEMP_LOW
        && $signed(regRdata[8:0]) <= asr_pkg::TEMP_HIGH)
        else $error("temperature outside clamp");
    a_speed_reset: assert property (!$past(rst_n) && rdS && !angleValid
        |=> regRdata == asr_pkg::SPEED_RESET)
        else $error("speed reset value wrong");
    // Main scenarios seen
    c_snap_read: cover property (regRead && snapRead);
    c_turn_read: cover property (rdT);
    c_unmapped: cover property (regRead && unmapped);
endmodule
bind asr_readout asr_readout_properties asr_readout_properties_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .angleValid(angleValid), .angleRaw(angleRaw),
    .anglePredicted(anglePredicted), .predictEnable(predictEnable), .tempRaw(tempRaw),
    .offsetTemperature25c(offsetTemperature25c), .updateRateSelect(updateRateSelect),
    .regRead(regRead), .regAddr(regAddr), .snapshot(snapshot), .snapRead(snapRead),
    .regRdata(regRdata), .regRvalid(regRvalid));

// >>> bench/asr_host_model.sv
// Host reader on the register port
`timescale 1ns/1ps
module asr_host_model (
    // Clock
    input wire logic sys_clk,
    // Register read port
    output logic regRead,
    output logic [5:0] regAddr,
    output logic snapRead,
    input wire logic [15:0] regRdata,
    input wire logic regRvalid
);
    initial begin
        regRead = 1'b0;
        regAddr = 6'h00;
        snapRead = 1'b0;
    end
    // Request held over its taking edge; address inverted after so nothing stale looks valid
    task automatic rd(input logic [5:0] a, input logic s, output logic [15:0] q);
        int n;
        n = 0;
        regRead <= 1'b1;
        regAddr <= a;
        snapRead <= s;
        @(posedge sys_clk) regRead <= 1'b0;
        snapRead <= 1'b0;
        regAddr <= ~a;
        do @(posedge sys_clk); while (regRvalid !== 1'b1 && ++n < 8);
        q = regRdata;
    endtask
    // Host conversion of the temperature field to degrees
    function automatic real deg(input logic [8:0] t);
        return ($signed(t) + 152) / 2.776;
    endfunction
endmodule

// >>> bench/asr_readout_tb.sv
// Self-checking bench for the readout registers
`timescale 1ns/1ps
module asr_readout_tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, angleValid = 1'b0, predictEnable = 1'b0, snapshot = 1'b0;
    logic [14:0] angleRaw = 15'h0000, anglePredicted = 15'h0000;
    logic [8:0] tempRaw = 9'h000, offsetTemperature25c = 9'h000;
    logic [1:0] updateRateSelect = 2'b00;
    logic regRead, snapRead, regRvalid;
    logic [5:0] regAddr;
    logic [15:0] regRdata, d, t0, s0;
    int n_fail = 0, n_checks = 0, cyc = 0;
    asr_readout asr_readout_inst (.sys_clk(sys_clk), .rst_n(rst_n), .angleValid(angleValid),
        .angleRaw(angleRaw), .anglePredicted(anglePredicted), .predictEnable(predictEnable),
        .tempRaw(tempRaw), .offsetTemperature25c(offsetTemperature25c),
        .updateRateSelect(updateRateSelect), .regRead(regRead), .regAddr(regAddr),
        .snapshot(snapshot), .snapRead(snapRead), .regRdata(regRdata), .regRvalid(regRvalid));
    asr_host_model asr_host_model_inst (.sys_clk(sys_clk), .regRead(regRead),
        .regAddr(regAddr), .snapRead(snapRead), .regRdata(regRdata), .regRvalid(regRvalid));
    always #12.5 sys_clk = ~sys_clk;
    // Hang guard; the longest scenario, t_temp, waits about two frames
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            complete_run();
        end
    end
    task complete_run();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask
    task rd(input logic [5:0] a, input logic s);
        asr_host_model_inst.rd(a, s, d);
    endtask
    // One update pulse, then room for the pipeline to settle
    task ang(input logic [14:0] r, input logic [14:0] p);
        angleValid <= 1'b1;
        angleRaw <= r;
        anglePredicted <= p;
        @(posedge sys_clk) angleValid <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task t_reset();
        rd(6'h03, 1'b0);
        chk(d, 16'h8000);
        rd(6'h04, 1'b0);
        chk(d, 16'h8000);
        rd(6'h3f, 1'b0);
        chk(d, 16'h0000);
    endtask
    task t_speed();
        ang(15'h0064, 15'h0000);
        ang(15'h00c8, 15'h0000);
        ang(15'h012c, 15'h0000);
        rd(6'h03, 1'b0);
        chk(d, 16'h80c8);
        rd(6'h03, 1'b0);
        chk(d, 16'h00c8);
        predictEnable <= 1'b1;
        ang(15'h0190, 15'h015e);
        rd(6'h03, 1'b0);
        chk(d, 16'h8096);
        predictEnable <= 1'b0;
        ang(15'h0064, 15'h0000);
        rd(6'h03, 1'b0);
        chk(d, 16'hff38);
    endtask
    task t_snap();
        rd(6'h04, 1'b0);
        snapshot <= 1'b1;
        @(posedge sys_clk) snapshot <= 1'b0;
        rd(6'h03, 1'b1);
        chk(d, 16'h7f38);
        rd(6'h04, 1'b1);
        chk(d & 16'h8000, 16'h0000);
        rd(6'h03, 1'b0);
        chk(d, 16'h7f38);
    endtask
    task t_turn();
        ang(15'h7f00, 15'h0000);
        rd(6'h04, 1'b0);
        chk(d & 16'h81ff, 16'h81ff);
        rd(6'h04, 1'b0);
        chk(d & 16'h8000, 16'h0000);
        ang(15'h0100, 15'h0000);
        rd(6'h04, 1'b0);
        chk(d & 16'h81ff, 16'h8000);
    endtask
    task t_temp();
        tempRaw <= 9'h064;
        offsetTemperature25c <= 9'h014;
        // Temperature is only refreshed at a frame boundary, so wait one full frame
        repeat ((asr_pkg::SUB_MAX_00 + 1) * asr_pkg::PROC_DIV + 4) @(posedge sys_clk);
        rd(6'h05, 1'b0);
        chk({7'h00, d[8:0]}, 16'h0050);
        chk(16'(int'(asr_host_model_inst.deg(d[8:0]))), 16'h0054);
        tempRaw <= 9'h100;
        offsetTemperature25c <= 9'h064;
        repeat ((asr_pkg::SUB_MAX_00 + 1) * asr_pkg::PROC_DIV + 4) @(posedge sys_clk);
        rd(6'h05, 1'b0);
        chk({7'h00, d[8:0]}, 16'h0115);
    endtask
    // Both counters sampled exactly one frame apart
    task t_frame();
        rd(6'h04, 1'b0);
        t0 = d;
        rd(6'h05, 1'b0);
        s0 = d;
        repeat ((asr_pkg::SUB_MAX_00 + 1) * asr_pkg::PROC_DIV - 4) @(posedge sys_clk);
        rd(6'h04, 1'b0);
        chk({10'h000, d[14:9]}, {10'h000, t0[14:9] + 6'h01});
        rd(6'h05, 1'b0);
        chk({9'h000, d[15:9]}, {9'h000, s0[15:9]});
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_speed();
        t_snap();
        t_turn();
        t_temp();
        t_frame();
        complete_run();
    end
endmodule
